// File: qupc_pkg.sv
// package of constants and types for the quadrature upconverter input control
// Functional notes
// (R1) sample word 14 bits, two's complement, msb sign
// (R2) words alternate i/q; interpolating dac all i
// (R3) first word after gate rise is i
// (R4) gate low feeds zeros into i and q
// (R5) two profile pins, second pin is lsb
// (R6) serial chip select active low, else ignore
// (R7) serial data pin bidirectional; control bit input-only
// (R8) serial out pin tristate unless input-only set
// (R9) resync input aborts transfer, keeps registers
// (R10) sleep input stops digital, pll optionally on
// (R11) reset high forces default state
// (R12) reset held high at least 5 cycles
// (R13) lock output follows pll lock live
// (R14) overflow output low unless filter overflows
// (R15) shared pin outputs sample clock outside single-tone
// (R16) source presents words on sample clock rise
// (R17) single-tone: shared pin strobe loads tuning word
// (R18) profile change applies tuning word without strobe
// (R19) three modes, quadrature after reset
// (R20) mode set only by serial control register
// (R21) inverse sinc and scale usable all modes; this code has no scale control, only invsinc_enable
// (R22) quadrature mode: both paths carry data
// (R23) single-tone: both data paths disabled
// (R24) single-tone: cosine source at active tuning word
package qupc_pkg;
	localparam int SAMPLE_W      = 14;
	localparam int TUNE_W        = 32;
	localparam int PROFILES      = 4;
	localparam int RESET_MIN_CYC = 5;
	localparam int SER_W         = 16;
	localparam int SER_ADDR_W    = 8;
	localparam logic [SER_ADDR_W-1:0] ADDR_CTRL    = 8'h00;
	localparam logic [SER_ADDR_W-1:0] ADDR_TUNE0   = 8'h10;
	localparam int CTRL_SDIO_IN_ONLY_BIT = 7;
	localparam int CTRL_MODE_LSB         = 0;
	localparam int CTRL_PLL_KEEP_BIT     = 2;
	localparam int CTRL_INVSINC_BIT      = 3;
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam int CLK_HZ        = 25_000_000;
	localparam int SCLK_DIV      = 4;
	localparam int PCLK_DIV      = 4;
	localparam logic [1:0] MODE_QUAD   = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_IDAC   = 2'h2;
	localparam logic [31:0] AXI_CMD    = 32'h0000_0000;
	localparam logic [31:0] AXI_SAMPLE = 32'h0000_0004;
	localparam logic [31:0] AXI_PINS   = 32'h0000_0008;
	localparam logic [31:0] AXI_STATUS = 32'h0000_000C;
	localparam logic [31:0] AXI_RDATA  = 32'h0000_0010;
	typedef enum logic [1:0] {QUPC_IDLE, QUPC_SHIFT, QUPC_DONE} qupc_ser_t;

	function automatic logic [1:0] qupc_edge(input logic prev, input logic cur);
		return {cur & ~prev, ~cur & prev};
	endfunction
endpackage

// File: qupc_link_if.sv
// pin-level link between upconverter front end and baseband controller
`timescale 1ns/1ns
interface qupc_link_if;
	import qupc_pkg::*;
	logic [SAMPLE_W-1:0] parallel_sample_bus;
	logic                transmit_gate;
	logic                profile_select_msb;
	logic                profile_select_lsb;
	logic                cs_n;
	logic                sclk;
	logic                sdio_o_host;
	logic                sdio_oe_host;
	logic                sdio_o_dev;
	logic                sdio_oe_dev;
	logic                serial_out_line;
	logic                serial_out_oe;
	logic                serial_resync_input;
	logic                digital_sleep_input;
	logic                hw_reset;
	logic                pll_lock;
	logic                interp_overflow_flag;
	logic                sample_clock_or_update_pin;
	logic                scu_pin_oe_dev;
	logic                scu_o_host;
	logic                scu_oe_host;
	logic                sdio_wire;
	logic                scu_wire;
	assign sdio_wire = sdio_oe_dev ? sdio_o_dev : (sdio_oe_host ? sdio_o_host : 1'b1);
	assign scu_wire  = scu_pin_oe_dev ? sample_clock_or_update_pin : (scu_oe_host ? scu_o_host : 1'b0);
	modport dev (input parallel_sample_bus, transmit_gate, profile_select_msb, profile_select_lsb, cs_n, sclk,
		sdio_wire, serial_resync_input, digital_sleep_input, hw_reset, scu_wire,
		output sdio_o_dev, sdio_oe_dev, serial_out_line, serial_out_oe, pll_lock, interp_overflow_flag,
		sample_clock_or_update_pin, scu_pin_oe_dev);
	modport host (output parallel_sample_bus, transmit_gate, profile_select_msb, profile_select_lsb, cs_n, sclk,
		sdio_o_host, sdio_oe_host, serial_resync_input, digital_sleep_input, hw_reset, scu_o_host, scu_oe_host,
		input sdio_wire, serial_out_line, serial_out_oe, pll_lock, interp_overflow_flag, scu_wire);
endinterface

// File: qupc_sync2.sv
// two-flop synchroniser for a bundle of levels
`timescale 1ns/1ns
module qupc_sync2 #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule // qupc_sync2

// File: qupc_device.sv
// upconverter front end: sample demux, mode control, serial port, status pins
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module qupc_device
	import qupc_pkg::*;
(
	input  wire logic                aclk,
	input  wire logic                aresetn,
	qupc_link_if.dev                 link,
	input  wire logic                pll_locked_in,
	input  wire logic                cic_overflow_in,
	output logic [SAMPLE_W-1:0]      i_path,
	output logic [SAMPLE_W-1:0]      q_path,
	output logic                     path_valid,
	output logic [TUNE_W-1:0]        active_tune,
	output logic                     cosine_enable,
	output logic [1:0]               mode,
	output logic                     invsinc_enable,
	output logic                     digital_asleep,
	output logic                     pll_keep_on
);
	localparam int PIN_N = SAMPLE_W + 9;
	logic [PIN_N-1:0]    pins_s;
	logic [SAMPLE_W-1:0] bus_s;
	logic                gate_s, ps_msb_s, ps_lsb_s, cs_n_s, sclk_s, sdio_s, resync_s, sleep_s, rst_s, scu_s;
	logic                sclk_d_r, scu_d_r;
	logic [7:0]          ctrl_r;
	logic [TUNE_W-1:0]   tune_r [PROFILES];
	logic [TUNE_W-1:0]   acc_tune_r;
	logic [1:0]          prof_d_r;
	logic                phase_q_r;
	logic [3:0]          pdiv_r;
	logic                pclk_r;
	logic [4:0]          bitcnt_r;
	logic [SER_W-1:0]    sh_r;
	logic                rd_r;
	logic [SER_ADDR_W-1:0] adr_r;
	logic [7:0]          rdsh_r;
	qupc_ser_t           ser_r;
	logic                srst;
	logic [1:0]          sclk_e, scu_e;
	logic [1:0]          prof;

	qupc_sync2 #(.W(PIN_N)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({link.parallel_sample_bus, link.transmit_gate, link.profile_select_msb,
			link.profile_select_lsb, link.cs_n, link.sclk, link.sdio_wire, link.serial_resync_input,
			link.digital_sleep_input, link.hw_reset}),
		.q       (pins_s)
	);
	assign {bus_s, gate_s, ps_msb_s, ps_lsb_s, cs_n_s, sclk_s, sdio_s, resync_s, sleep_s, rst_s} = pins_s;
	qupc_sync2 #(.W(1)) u_sync_scu (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (link.scu_wire),
		.q       (scu_s)
	);

	assign srst   = !aresetn || rst_s; // R11
	assign prof   = {ps_msb_s, ps_lsb_s}; // R5
	assign sclk_e = qupc_edge(sclk_d_r, sclk_s);
	assign scu_e  = qupc_edge(scu_d_r, scu_s);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sclk_d_r <= 1'b0;
			scu_d_r  <= 1'b0;
			prof_d_r <= 2'h0;
		end else begin
			sclk_d_r <= sclk_s;
			scu_d_r  <= scu_s;
			prof_d_r <= prof;
		end
	end

	// serial port: 16-bit frame, bit15 read, bits14:8 address, bits7:0 data, msb first
	always_ff @(posedge aclk) begin
		if (srst) begin
			ser_r    <= QUPC_IDLE;
			bitcnt_r <= '0;
			sh_r     <= '0;
			rd_r     <= 1'b0;
			adr_r    <= '0;
			rdsh_r   <= '0;
			ctrl_r   <= CTRL_RESET; // R19
			for (int k = 0; k < PROFILES; k++) begin
				tune_r[k] <= '0;
			end
		end else if (resync_s || cs_n_s) begin // R6 R9
			ser_r    <= QUPC_IDLE;
			bitcnt_r <= '0;
		end else begin
			unique case (ser_r)
				QUPC_IDLE, QUPC_SHIFT: begin
					ser_r <= QUPC_SHIFT;
					if (sclk_e[1]) begin
						sh_r     <= {sh_r[SER_W-2:0], sdio_s};
						bitcnt_r <= bitcnt_r + 5'd1;
						if (bitcnt_r == 5'd7) begin
							rd_r  <= sh_r[6];
							adr_r <= {1'b0, sh_r[5:0], sdio_s};
							rdsh_r <= (({sh_r[5:0], sdio_s} == 7'(ADDR_CTRL))) ? ctrl_r :
								tune_r[sh_r[2:1]][8*{sh_r[0], sdio_s} +: 8];
						end
						if (bitcnt_r == 5'(SER_W - 1)) begin
							ser_r <= QUPC_DONE;
							if (!rd_r) begin
								if (adr_r == ADDR_CTRL) begin
									ctrl_r <= {sh_r[6:0], sdio_s}; // R20 R7
								end else if (adr_r[SER_ADDR_W-1:4] == ADDR_TUNE0[SER_ADDR_W-1:4]) begin
									tune_r[adr_r[3:2]][8*adr_r[1:0] +: 8] <= {sh_r[6:0], sdio_s};
								end
							end
						end
					end
					if (sclk_e[0] && rd_r && bitcnt_r >= 5'd8) begin
						rdsh_r <= {rdsh_r[6:0], 1'b0};
					end
				end
				QUPC_DONE: begin
					ser_r <= QUPC_DONE;
				end
			endcase
		end
	end

	assign mode           = ctrl_r[CTRL_MODE_LSB +: 2];
	assign invsinc_enable = ctrl_r[CTRL_INVSINC_BIT]; // R21
	assign pll_keep_on    = ctrl_r[CTRL_PLL_KEEP_BIT];

	// serial read data: sdio when bidirectional, otherwise separate out pin
	always_ff @(posedge aclk) begin
		if (srst) begin
			link.sdio_o_dev      <= 1'b0;
			link.sdio_oe_dev     <= 1'b0;
			link.serial_out_line <= 1'b0;
			link.serial_out_oe   <= 1'b0;
		end else begin
			link.sdio_o_dev      <= rdsh_r[7];
			link.serial_out_line <= rdsh_r[7];
			link.sdio_oe_dev     <= !cs_n_s && rd_r && ser_r == QUPC_SHIFT && bitcnt_r >= 5'd8
				&& !ctrl_r[CTRL_SDIO_IN_ONLY_BIT]; // R7
			link.serial_out_oe   <= !cs_n_s && rd_r && ser_r == QUPC_SHIFT && bitcnt_r >= 5'd8
				&& ctrl_r[CTRL_SDIO_IN_ONLY_BIT]; // R8
		end
	end

	// sample clock divider and demux
	always_ff @(posedge aclk) begin
		if (srst) begin
			pdiv_r     <= '0;
			pclk_r     <= 1'b0;
			phase_q_r  <= 1'b0;
			i_path     <= '0;
			q_path     <= '0;
			path_valid <= 1'b0;
		end else if (sleep_s) begin // R10
			path_valid <= 1'b0;
			// restart the divider so the pin shows no short phase on wake
			pdiv_r     <= '0;
			pclk_r     <= 1'b0;
		end else begin
			path_valid <= 1'b0;
			if (pdiv_r == 4'(PCLK_DIV - 1)) begin
				pdiv_r <= '0;
				pclk_r <= !pclk_r;
				if (!pclk_r && mode != MODE_SINGLE) begin // R15 R16
					path_valid <= 1'b1;
					if (!gate_s) begin
						i_path    <= '0; // R4
						q_path    <= '0;
						phase_q_r <= 1'b0; // R3
					end else if (mode == MODE_IDAC) begin
						i_path    <= bus_s; // R2 R1
					end else begin
						if (phase_q_r) q_path <= bus_s; // R22
						else i_path <= bus_s;
						phase_q_r <= !phase_q_r; // R2
					end
				end
			end else begin
				pdiv_r <= pdiv_r + 4'd1;
			end
			if (mode == MODE_SINGLE) begin // R23
				i_path    <= '0;
				q_path    <= '0;
				phase_q_r <= 1'b0;
			end
		end
	end

	// tuning word: update strobe or profile change makes it active
	always_ff @(posedge aclk) begin
		if (srst) begin
			acc_tune_r    <= '0;
			active_tune   <= '0;
			cosine_enable <= 1'b0;
		end else begin
			if (prof != prof_d_r) acc_tune_r <= tune_r[prof]; // R18
			else if (mode == MODE_SINGLE && scu_e[1]) acc_tune_r <= tune_r[prof]; // R17
			active_tune   <= acc_tune_r;
			cosine_enable <= mode == MODE_SINGLE && !sleep_s; // R24
		end
	end

	always_ff @(posedge aclk) begin
		if (srst) begin
			link.pll_lock                   <= 1'b0;
			link.interp_overflow_flag       <= 1'b0;
			link.sample_clock_or_update_pin <= 1'b0;
			link.scu_pin_oe_dev             <= 1'b0;
			digital_asleep                  <= 1'b0;
		end else begin
			link.pll_lock                   <= pll_locked_in; // R13
			link.interp_overflow_flag       <= cic_overflow_in && mode != MODE_SINGLE; // R14
			link.sample_clock_or_update_pin <= pclk_r && !sleep_s;
			link.scu_pin_oe_dev             <= mode != MODE_SINGLE; // R15
			digital_asleep                  <= sleep_s; // R10
		end
	end
endmodule // qupc_device

// File: qupc_host.sv
// baseband controller: axi4-lite command registers driving the upconverter pins
`timescale 1ns/1ns
module qupc_host
	import qupc_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	qupc_link_if.host        link,
	input  wire logic [31:0] s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [31:0] s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready
);
	logic [31:0] awa_r, wd_r, cmd_r;
	logic        aw_h_r, w_h_r;
	logic [SAMPLE_W-1:0] sample_r;
	logic        gate_r;
	logic [15:0] sfr_r;
	logic [4:0]  scnt_r;
	logic [1:0]  sdiv_r;
	logic        busy_r;
	logic [7:0]  rdata_r;
	logic [2:0]  lk_s;
	logic        pclk_d_r;
	logic        wr_go;
	logic [1:0]  pclk_e;

	qupc_sync2 #(.W(3)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({link.scu_wire, link.sdio_wire, link.pll_lock}),
		.q       (lk_s)
	);
	assign wr_go = aw_h_r && w_h_r && !s_bvalid;
	assign pclk_e = qupc_edge(pclk_d_r, lk_s[2]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_awready <= 1'b1;
			s_wready  <= 1'b1;
			aw_h_r    <= 1'b0;
			w_h_r     <= 1'b0;
			awa_r     <= '0;
			wd_r      <= '0;
			s_bvalid  <= 1'b0;
			s_bresp   <= 2'b00;
		end else begin
			if (s_awvalid && s_awready) begin
				awa_r     <= s_awaddr;
				aw_h_r    <= 1'b1;
				s_awready <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				wd_r     <= s_wdata;
				w_h_r    <= 1'b1;
				s_wready <= 1'b0;
			end
			if (wr_go) begin
				s_bvalid <= 1'b1;
				s_bresp  <= (awa_r[7:0] <= AXI_PINS[7:0]) ? 2'b00 : 2'b10;
			end
			if (s_bvalid && s_bready) begin
				s_bvalid  <= 1'b0;
				aw_h_r    <= 1'b0;
				w_h_r     <= 1'b0;
				s_awready <= 1'b1;
				s_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_r    <= '0;
			sample_r <= '0;
			gate_r   <= 1'b0;
			link.profile_select_msb  <= 1'b0;
			link.profile_select_lsb  <= 1'b0;
			link.serial_resync_input <= 1'b0;
			link.digital_sleep_input <= 1'b0;
			link.hw_reset            <= 1'b0;
			link.scu_o_host          <= 1'b0;
		end else if (wr_go && s_wstrb[0]) begin
			unique case (awa_r[7:0])
				AXI_CMD[7:0]:    cmd_r <= wd_r;
				AXI_SAMPLE[7:0]: begin
					sample_r <= wd_r[SAMPLE_W-1:0]; // R1
					gate_r   <= wd_r[16];
				end
				AXI_PINS[7:0]: begin
					{link.profile_select_msb, link.profile_select_lsb} <= wd_r[1:0]; // R5
					link.serial_resync_input <= wd_r[2];
					link.digital_sleep_input <= wd_r[3];
					link.hw_reset            <= wd_r[4]; // R12
					link.scu_o_host          <= wd_r[5]; // R17
				end
				default: ;
			endcase
		end
	end

	// parallel words change on sample clock rise
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pclk_d_r                 <= 1'b0;
			link.parallel_sample_bus <= '0;
			link.transmit_gate       <= 1'b0;
			link.scu_oe_host         <= 1'b0;
		end else begin
			pclk_d_r <= lk_s[2];
			link.scu_oe_host <= cmd_r[17];
			if (pclk_e[1]) begin // R16
				link.parallel_sample_bus <= sample_r;
				link.transmit_gate       <= gate_r; // R3
			end
		end
	end

	// serial master: write cmd low 16 bits as one frame, bit16 starts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_r    <= 1'b0;
			sfr_r     <= '0;
			scnt_r    <= '0;
			sdiv_r    <= '0;
			rdata_r   <= '0;
			link.cs_n <= 1'b1;
			link.sclk <= 1'b0;
			link.sdio_o_host  <= 1'b0;
			link.sdio_oe_host <= 1'b0;
		end else if (!busy_r) begin
			if (wr_go && awa_r[7:0] == AXI_CMD[7:0] && wd_r[16]) begin
				busy_r    <= 1'b1;
				sfr_r     <= wd_r[15:0];
				scnt_r    <= '0;
				link.cs_n <= 1'b0; // R6
				link.sdio_o_host  <= wd_r[15];
				link.sdio_oe_host <= 1'b1;
			end
		end else begin
			sdiv_r <= sdiv_r + 2'd1;
			if (sdiv_r == 2'(SCLK_DIV - 1)) begin
				link.sclk <= !link.sclk;
				if (link.sclk) begin
					scnt_r <= scnt_r + 5'd1;
					sfr_r  <= {sfr_r[14:0], 1'b0};
					link.sdio_o_host <= sfr_r[14];
					if (sfr_r[15] == 1'b0 && scnt_r == 5'd7 && cmd_r[15]) link.sdio_oe_host <= 1'b0;
					if (scnt_r == 5'd15) begin
						busy_r    <= 1'b0;
						link.cs_n <= 1'b1;
						link.sdio_oe_host <= 1'b0;
					end
				end else if (scnt_r >= 5'd8) begin
					rdata_r <= {rdata_r[6:0], cmd_r[18] ? link.serial_out_line : lk_s[1]};
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= '0;
			s_rresp   <= 2'b00;
		end else if (s_arvalid && s_arready) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b1;
			s_rresp   <= 2'b00;
			unique case (s_araddr[7:0])
				AXI_CMD[7:0]:    s_rdata <= cmd_r;
				AXI_SAMPLE[7:0]: s_rdata <= {15'h0000, gate_r, 2'b00, sample_r};
				AXI_STATUS[7:0]: s_rdata <= {29'h0000_0000, link.interp_overflow_flag, lk_s[0], busy_r};
				AXI_RDATA[7:0]:  s_rdata <= {24'h00_0000, rdata_r};
				default: begin
					s_rdata <= '0;
					s_rresp <= 2'b10;
				end
			endcase
		end else if (s_rvalid && s_rready) begin
			s_rvalid  <= 1'b0;
			s_arready <= 1'b1;
		end
	end
endmodule // qupc_host

// File: qupc_link_checker.sv
// concurrent checks on the pin-level link between the two ends
`timescale 1ns/1ns
module qupc_link_checker
	import qupc_pkg::*;
(
	input wire logic                aclk,
	input wire logic                aresetn,
	input wire logic [SAMPLE_W-1:0] parallel_sample_bus,
	input wire logic                cs_n,
	input wire logic                sclk,
	input wire logic                sdio_oe_host,
	input wire logic                sdio_oe_dev,
	input wire logic                serial_out_oe,
	input wire logic                hw_reset,
	input wire logic                digital_sleep_input,
	input wire logic                sample_clock_or_update_pin,
	input wire logic                scu_pin_oe_dev,
	input wire logic                scu_oe_host
);
	logic [4:0] rise_cnt_r;
	logic       sclk_q_r;

	always_ff @(posedge aclk) begin
		sclk_q_r <= sclk;
	end

	// serial clock rises seen inside the current frame
	always_ff @(posedge aclk) begin
		if (!aresetn || cs_n)
			rise_cnt_r <= 5'h0;
		else if (sclk && !sclk_q_r)
			rise_cnt_r <= rise_cnt_r + 5'h1;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_pclk_high;
		sample_clock_or_update_pin [*4] ##1 !sample_clock_or_update_pin;
	endsequence
	sequence s_pclk_low;
		!sample_clock_or_update_pin [*4] ##1 sample_clock_or_update_pin;
	endsequence
	sequence s_pclk_off;
		##[0:4] !scu_pin_oe_dev;
	endsequence

	chk_sclk_in_frame: assert property ($changed(sclk) |-> !cs_n || !$past(cs_n))
		else $error("serial clock moved while unselected");
	chk_ser_idle: assert property (cs_n && $past(cs_n) |-> !sdio_oe_dev && !serial_out_oe)
		else $error("device drives serial pins while unselected");
	chk_frame_len: assert property ($rose(cs_n) |-> rise_cnt_r == 5'h10)
		else $error("serial frame is not sixteen clocks");
	chk_sdio_one_driver: assert property (sdio_oe_dev |-> !sdio_oe_host)
		else $error("both ends drive the serial data pin");
	chk_sdo_exclusive: assert property (serial_out_oe |-> !sdio_oe_dev)
		else $error("serial out driven beside bidirectional pin");
	chk_reset_width: assert property ($rose(hw_reset) |-> hw_reset [*5])
		else $error("hardware reset pulse too short");
	chk_scu_one_driver: assert property (scu_oe_host |-> !scu_pin_oe_dev)
		else $error("both ends drive the shared clock pin");
	chk_pclk_high: assert property (disable iff (!aresetn || hw_reset || digital_sleep_input)
		$rose(sample_clock_or_update_pin) && scu_pin_oe_dev |-> s_pclk_high or s_pclk_off)
		else $error("sample clock high phase wrong");
	chk_pclk_low: assert property (disable iff (!aresetn || hw_reset || digital_sleep_input)
		$fell(sample_clock_or_update_pin) && scu_pin_oe_dev |-> s_pclk_low or s_pclk_off)
		else $error("sample clock low phase wrong");
	chk_bus_at_fall: assert property (disable iff (!aresetn || hw_reset)
		$fell(sample_clock_or_update_pin) && scu_pin_oe_dev |-> $stable(parallel_sample_bus))
		else $error("sample bus changed at the sampling edge");
endmodule // qupc_link_checker

// File: tb_quadrature_upconverter_input_control.sv
// self-checking bench: host and device joined over the link, driven through axi4-lite
`timescale 1ns/1ns
module tb_quadrature_upconverter_input_control
	import qupc_pkg::*;
;
	logic                aclk, aresetn, pll_locked_in, cic_overflow_in;
	logic [31:0]         s_awaddr, s_wdata, s_araddr, s_rdata, rd;
	logic [3:0]          s_wstrb;
	logic [1:0]          s_bresp, s_rresp, rr, mode;
	logic                s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic                s_arvalid, s_arready, s_rvalid, s_rready;
	logic [SAMPLE_W-1:0] i_path, q_path;
	logic [TUNE_W-1:0]   active_tune;
	logic                path_valid, cosine_enable, invsinc_enable, digital_asleep, pll_keep_on;
	int                  n_mismatch, tests_run, cycles;

	qupc_link_if link_if();
	qupc_device i_qupc_device(.aclk, .aresetn, .link(link_if), .pll_locked_in, .cic_overflow_in, .i_path,
		.q_path, .path_valid, .active_tune, .cosine_enable, .mode, .invsinc_enable, .digital_asleep, .pll_keep_on);
	qupc_host i_qupc_host(.aclk, .aresetn, .link(link_if), .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
		.s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
		.s_rresp, .s_rvalid, .s_rready);
	qupc_link_checker i_qupc_link_checker(.aclk, .aresetn, .parallel_sample_bus(link_if.parallel_sample_bus),
		.cs_n(link_if.cs_n), .sclk(link_if.sclk), .sdio_oe_host(link_if.sdio_oe_host),
		.sdio_oe_dev(link_if.sdio_oe_dev), .serial_out_oe(link_if.serial_out_oe), .hw_reset(link_if.hw_reset),
		.digital_sleep_input(link_if.digital_sleep_input),
		.sample_clock_or_update_pin(link_if.sample_clock_or_update_pin),
		.scu_pin_oe_dev(link_if.scu_pin_oe_dev), .scu_oe_host(link_if.scu_oe_host));

	always #20 aclk = ~aclk;

	task automatic close_out;
		if (n_mismatch == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 40000) begin
			n_mismatch++;
			close_out();
		end
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
		s_awaddr  <= a;
		s_awvalid <= 1'b1;
		s_wdata   <= d;
		s_wvalid  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_awvalid && s_awready)
				s_awvalid <= 1'b0;
			if (s_wvalid && s_wready)
				s_wvalid <= 1'b0;
		end while (s_bvalid !== 1'b1);
	endtask

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		s_araddr  <= a;
		s_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_arvalid && s_arready)
				s_arvalid <= 1'b0;
		end while (s_rvalid !== 1'b1);
		d = s_rdata;
		r = s_rresp;
	endtask

	// bus traffic gives the pins time to cross the synchronisers
	task automatic settle;
		repeat (4) @(posedge aclk);
		axi_rd(AXI_STATUS, rd, rr);
		axi_rd(AXI_STATUS, rd, rr);
	endtask

	// one serial frame, finished when the host reports idle again
	task automatic ser(input logic [31:0] c);
		axi_wr(AXI_CMD, c);
		wait (link_if.cs_n === 1'b0);
		wait (link_if.cs_n === 1'b1);
		@(posedge aclk);
		do axi_rd(AXI_STATUS, rd, rr); while (rd[0] !== 1'b0);
	endtask

	task automatic wv(input int n);
		repeat (n) do @(posedge aclk); while (path_valid !== 1'b1);
	endtask

	initial begin
		aclk = 1'b0; aresetn = 1'b0; pll_locked_in = 1'b0; cic_overflow_in = 1'b0;
		s_awaddr = 32'h0; s_awvalid = 1'b0; s_wdata = 32'h0; s_wstrb = 4'hF; s_wvalid = 1'b0;
		s_bready = 1'b1; s_araddr = 32'h0; s_arvalid = 1'b0; s_rready = 1'b1;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		cmp(mode, MODE_QUAD);
		cmp(link_if.serial_out_oe, 1'b0);
		pll_locked_in   <= 1'b1;
		cic_overflow_in <= 1'b1;
		settle();
		cmp(link_if.pll_lock, 1'b1);
		cmp(link_if.interp_overflow_flag, 1'b1);
		pll_locked_in   <= 1'b0;
		cic_overflow_in <= 1'b0;
		settle();
		cmp(rd[2:1], 2'h0);
		cmp(link_if.interp_overflow_flag, 1'b0);
		axi_rd(32'h0000_0020, rd, rr);
		cmp(rd, 32'h0);
		cmp(rr, 2'h2);
		// quadrature stream: negative word, first after gate is in-phase
		axi_wr(AXI_SAMPLE, 32'h0001_2001);
		do @(posedge aclk); while (!(path_valid === 1'b1 && i_path === 14'h2001));
		cmp(q_path, 14'h0);
		wv(1);
		cmp(q_path, 14'h2001);
		cmp(i_path, 14'h2001);
		axi_wr(AXI_SAMPLE, 32'h0000_2001);
		wv(3);
		cmp({i_path, q_path}, 28'h0);
		// interpolating dac: every word lands in-phase
		ser(32'h0001_000E);
		cmp(mode, MODE_IDAC);
		cmp(invsinc_enable, 1'b1);
		cmp(pll_keep_on, 1'b1);
		axi_wr(AXI_SAMPLE, 32'h0001_1FFF);
		wv(4);
		cmp({i_path, q_path}, {14'h1FFF, 14'h0});
		wv(1);
		cmp({i_path, q_path}, {14'h1FFF, 14'h0});
		axi_wr(AXI_SAMPLE, 32'h0000_0000);
		wv(3);
		cmp({i_path, q_path}, 28'h0);
		// single tone
		ser(32'h0001_0001);
		cmp(mode, MODE_SINGLE);
		cmp(cosine_enable, 1'b1);
		axi_wr(AXI_SAMPLE, 32'h0001_0155);
		settle();
		cmp(link_if.scu_pin_oe_dev, 1'b0);
		cmp({i_path, q_path}, 28'h0);
		for (int p = 1; p < 3; p++)
			for (int b = 0; b < 4; b++)
				ser({16'h0001, 8'(ADDR_TUNE0 + 4 * p + b), (p == 1) ? 8'hA5 : 8'h5A});
		axi_wr(AXI_PINS, 32'h0000_0001);
		settle();
		cmp(active_tune, 32'hA5A5_A5A5);
		axi_wr(AXI_PINS, 32'h0000_0002);
		settle();
		cmp(active_tune, 32'h5A5A_5A5A);
		for (int b = 0; b < 4; b++)
			ser({16'h0001, 8'(ADDR_TUNE0 + 8 + b), 8'h3C});
		settle();
		cmp(active_tune, 32'h5A5A_5A5A);
		axi_wr(AXI_CMD, 32'h0002_0000);
		axi_wr(AXI_PINS, 32'h0000_0022);
		settle();
		cmp(active_tune, 32'h3C3C_3C3C);
		axi_wr(AXI_PINS, 32'h0000_0002);
		axi_wr(AXI_CMD, 32'h0000_0000);
		// serial read back, bidirectional then input-only
		ser(32'h0001_8000);
		axi_rd(AXI_RDATA, rd, rr);
		cmp(rd[7:0], 8'h01);
		ser(32'h0001_0089);
		cmp(invsinc_enable, 1'b1);
		ser(32'h0005_8000);
		axi_rd(AXI_RDATA, rd, rr);
		cmp(rd[7:0], 8'h89);
		// resync pulse cuts a mode write short: control must keep single tone
		axi_wr(AXI_CMD, 32'h0001_0002);
		axi_wr(AXI_PINS, 32'h0000_0004);
		axi_wr(AXI_PINS, 32'h0000_0000);
		wait (link_if.cs_n === 1'b1);
		settle();
		cmp(mode, MODE_SINGLE);
		axi_wr(AXI_PINS, 32'h0000_0008);
		settle();
		cmp(digital_asleep, 1'b1);
		axi_wr(AXI_PINS, 32'h0000_0010);
		settle();
		axi_wr(AXI_PINS, 32'h0000_0000);
		settle();
		cmp(mode, MODE_QUAD);
		cmp(invsinc_enable, 1'b0);
		close_out();
	end
endmodule // tb_quadrature_upconverter_input_control
